// >>> lbpg_pkg.sv
// Constants, types and register map of the LED breath pattern generator
package lbpg_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;

  // Register offsets
  localparam logic [7:0] ADDR_CH_LEVEL_BASE = 8'h01;
  localparam logic [7:0] ADDR_RISE = 8'h10;
  localparam logic [7:0] ADDR_FALL = 8'h11;
  localparam logic [7:0] ADDR_ON = 8'h12;
  localparam logic [7:0] ADDR_OFF = 8'h13;
  localparam logic [7:0] ADDR_GAP = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h15;
  localparam logic [7:0] ADDR_AUDIO_SEL = 8'h43;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MULTI_BIT = 1;
  localparam int CTRL_LIN_BIT = 2;
  localparam int CTRL_CNT_LSB = 4;
  localparam int CTRL_CNT_W = 3;
  localparam int NUM_CH = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Time limits and steps, milliseconds
  localparam int RISE_MAX_MS = 8390;
  localparam int FALL_MAX_MS = 8390;
  localparam int ON_MIN_MS = 50;
  localparam int ON_MAX_MS = 4200;
  localparam int OFF_MIN_MS = 80;
  localparam int OFF_MAX_MS = 8400;
  localparam int GAP_MAX_MS = 540;
  localparam int RAMP_STEP_MS = 33;
  localparam int ON_STEP_MS = 17;
  localparam int OFF_STEP_MS = 33;
  localparam int GAP_STEP_MS = 3;

  // Ramp has 256 phase steps; one step lasts code * RAMP_CYC cycles
  localparam int PHASE_STEPS = 256;
  localparam int RAMP_CYC = CYC_PER_MS * RAMP_STEP_MS / PHASE_STEPS;
  localparam logic [7:0] RISE_CODE_MAX = 8'(RISE_MAX_MS / RAMP_STEP_MS);
  localparam logic [7:0] FALL_CODE_MAX = 8'(FALL_MAX_MS / RAMP_STEP_MS);
  localparam logic [7:0] PHASE_FULL = 8'hff;
  localparam logic [7:0] PHASE_ZERO = 8'h00;

  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] on_t;
    logic [7:0] off_t;
    logic [7:0] gap;
    logic [CTRL_CNT_W-1:0] pulses;
    logic multi;
    logic linear;
    logic en;
  } lbpg_cfg_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RISE = 6'b000010,
    ST_ON = 6'b000100,
    ST_FALL = 6'b001000,
    ST_GAP = 6'b010000,
    ST_OFF = 6'b100000
  } lbpg_state_e;

endpackage

// >>> lbpg_top.sv
// LED breath pattern generator: shared timing engine driving four channels
`timescale 1ns/1ps
module lbpg_top import lbpg_pkg::*; #(
  parameter int TICK_CYC = CYC_PER_MS
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [NUM_CH-1:0][7:0] audio_level_in,
  output logic [NUM_CH-1:0][7:0] led_drive_out,
  output logic [5:0] pattern_state_out
);

  lbpg_cfg_s cfg_r;
  logic [NUM_CH-1:0][7:0] level_r;
  logic [NUM_CH-1:0] audio_sel_r;
  logic [7:0] rdata_nxt;
  lbpg_state_e state_r, state_nxt;
  logic [15:0] ms_div_r;
  logic [13:0] ms_cnt_r;
  logic [19:0] sub_r;
  logic [7:0] phase_r;
  logic [CTRL_CNT_W-1:0] pulse_idx_r;
  logic ms_tick, sub_wrap, stage_done, ramp_end;
  logic [7:0] rise_code, fall_code, curve;
  logic [13:0] on_ms, off_ms, gap_ms, wait_ms;
  logic [19:0] ramp_len;
  logic [15:0] t_on, t_off, t_gap;
  logic [12:0] log_shift;

  // Register writes
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_r <= '0;
      level_r <= '0;
      audio_sel_r <= '0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_RISE: cfg_r.rise <= reg_wdata_in;
        ADDR_FALL: cfg_r.fall <= reg_wdata_in;
        ADDR_ON: cfg_r.on_t <= reg_wdata_in;
        ADDR_OFF: cfg_r.off_t <= reg_wdata_in;
        ADDR_GAP: cfg_r.gap <= reg_wdata_in;
        ADDR_CTRL: begin
          cfg_r.en <= reg_wdata_in[CTRL_EN_BIT];
          cfg_r.multi <= reg_wdata_in[CTRL_MULTI_BIT];
          cfg_r.linear <= reg_wdata_in[CTRL_LIN_BIT];
          cfg_r.pulses <= reg_wdata_in[CTRL_CNT_LSB +: CTRL_CNT_W];
        end
        ADDR_AUDIO_SEL: audio_sel_r <= reg_wdata_in[NUM_CH-1:0];
        default: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (reg_addr_in == ADDR_CH_LEVEL_BASE + 8'(i)) begin
              level_r[i] <= reg_wdata_in;
            end
          end
        end
      endcase
    end
  end

  // Read data
  always_comb begin
    rdata_nxt = RESET_BYTE;
    case (reg_addr_in)
      ADDR_RISE: rdata_nxt = cfg_r.rise;
      ADDR_FALL: rdata_nxt = cfg_r.fall;
      ADDR_ON: rdata_nxt = cfg_r.on_t;
      ADDR_OFF: rdata_nxt = cfg_r.off_t;
      ADDR_GAP: rdata_nxt = cfg_r.gap;
      ADDR_CTRL: begin
        rdata_nxt[CTRL_EN_BIT] = cfg_r.en;
        rdata_nxt[CTRL_MULTI_BIT] = cfg_r.multi;
        rdata_nxt[CTRL_LIN_BIT] = cfg_r.linear;
        rdata_nxt[CTRL_CNT_LSB +: CTRL_CNT_W] = cfg_r.pulses;
      end
      ADDR_AUDIO_SEL: rdata_nxt[NUM_CH-1:0] = audio_sel_r;
      default: begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (reg_addr_in == ADDR_CH_LEVEL_BASE + 8'(i)) begin
            rdata_nxt = level_r[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= RESET_BYTE;
    end else begin
      reg_rdata_out <= rdata_nxt;
    end
  end

  // Shared time settings, clamped to their ranges
  always_comb begin
    t_on = 16'(ON_MIN_MS) + 16'(cfg_r.on_t) * 16'(ON_STEP_MS);
    t_off = 16'(OFF_MIN_MS) + 16'(cfg_r.off_t) * 16'(OFF_STEP_MS);
    t_gap = 16'(cfg_r.gap) * 16'(GAP_STEP_MS);
    rise_code = (cfg_r.rise > RISE_CODE_MAX) ? RISE_CODE_MAX : cfg_r.rise;
    fall_code = (cfg_r.fall > FALL_CODE_MAX) ? FALL_CODE_MAX : cfg_r.fall;
    on_ms = (t_on > 16'(ON_MAX_MS)) ? 14'(ON_MAX_MS) : t_on[13:0];
    off_ms = (t_off > 16'(OFF_MAX_MS)) ? 14'(OFF_MAX_MS) : t_off[13:0];
    gap_ms = (t_gap > 16'(GAP_MAX_MS)) ? 14'(GAP_MAX_MS) : t_gap[13:0];
  end

  // Stage timing
  assign ms_tick = (ms_div_r == 16'(TICK_CYC - 1));
  assign ramp_len = 20'(state_r == ST_FALL ? fall_code : rise_code) * 20'(RAMP_CYC);
  assign sub_wrap = (sub_r == ramp_len - 20'd1);
  assign wait_ms = (state_r == ST_ON) ? on_ms : (state_r == ST_GAP) ? gap_ms : off_ms;
  assign stage_done = (ms_cnt_r >= wait_ms);

  always_comb begin
    ramp_end = 1'b0;
    if (state_r == ST_RISE) begin
      ramp_end = (rise_code == 8'd0) || (phase_r == PHASE_FULL && sub_wrap);
    end else if (state_r == ST_FALL) begin
      ramp_end = (fall_code == 8'd0) || (phase_r == PHASE_ZERO && sub_wrap);
    end
  end

  // One sequencer for all channels keeps them in lockstep
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (cfg_r.en) state_nxt = ST_RISE;
      ST_RISE: if (ramp_end) state_nxt = ST_ON;
      ST_ON: if (stage_done) state_nxt = ST_FALL;
      ST_FALL: begin
        if (ramp_end) begin
          if (cfg_r.multi && pulse_idx_r < cfg_r.pulses) begin
            state_nxt = ST_GAP;
          end else begin
            state_nxt = ST_OFF;
          end
        end
      end
      ST_GAP: if (stage_done) state_nxt = ST_RISE;
      ST_OFF: if (stage_done) state_nxt = ST_RISE;
      default: state_nxt = ST_IDLE;
    endcase
    if (!cfg_r.en) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pulse counter within a cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pulse_idx_r <= '0;
    end else if (state_nxt == ST_IDLE || state_nxt == ST_OFF) begin
      pulse_idx_r <= '0;
    end else if (state_r == ST_FALL && state_nxt == ST_GAP) begin
      pulse_idx_r <= pulse_idx_r + 1'b1;
    end
  end

  // Millisecond timer, restarted at every stage change
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ms_div_r <= '0;
      ms_cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      ms_div_r <= '0;
      ms_cnt_r <= '0;
    end else if (ms_tick) begin
      ms_div_r <= '0;
      ms_cnt_r <= ms_cnt_r + 14'd1;
    end else begin
      ms_div_r <= ms_div_r + 16'd1;
    end
  end

  // Ramp phase
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sub_r <= '0;
      phase_r <= PHASE_ZERO;
    end else if (state_nxt != state_r) begin
      sub_r <= '0;
      phase_r <= (state_nxt == ST_FALL) ? PHASE_FULL : PHASE_ZERO;
    end else if (state_r == ST_RISE || state_r == ST_FALL) begin
      if (sub_wrap) begin
        sub_r <= '0;
        phase_r <= (state_r == ST_RISE) ? phase_r + 8'd1 : phase_r - 8'd1;
      end else begin
        sub_r <= sub_r + 20'd1;
      end
    end
  end

  // Brightness curve: exponential segments or straight line
  assign log_shift = 13'({1'b1, phase_r[4:0]}) << phase_r[7:5];
  assign curve = cfg_r.linear ? phase_r : log_shift[12:5];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [15:0] prod;
      logic [7:0] pat;
      assign prod = 16'(level_r[ch]) * 16'(curve);
      always_comb begin
        pat = RESET_BYTE;
        if (state_r == ST_ON) begin
          pat = level_r[ch];
        end else if ((state_r == ST_RISE || state_r == ST_FALL) && phase_r != PHASE_ZERO) begin
          pat = prod[15:8];
        end
      end
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          led_drive_out[ch] <= RESET_BYTE;
        end else begin
          led_drive_out[ch] <= audio_sel_r[ch] ? audio_level_in[ch] : pat;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pattern_state_out <= ST_IDLE;
    end else begin
      pattern_state_out <= state_r;
    end
  end

endmodule

// >>> lbpg_top_sva.sv
// Port assertions for the LED breath pattern generator
`timescale 1ns/1ps
module lbpg_top_sva import lbpg_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [NUM_CH-1:0][7:0] audio_level_in,
  input wire logic [NUM_CH-1:0][7:0] led_drive_out,
  input wire logic [5:0] pattern_state_out
);
  logic [3:0] sel_r;
  logic en_r;
  logic [NUM_CH-1:0][7:0] lvl_r;
  // Shadow copies of written registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_r <= 4'h0;
      en_r <= 1'b0;
      lvl_r <= '0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADDR_AUDIO_SEL) sel_r <= reg_wdata_in[3:0];
      if (reg_addr_in == ADDR_CTRL) en_r <= reg_wdata_in[CTRL_EN_BIT];
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr_in == ADDR_CH_LEVEL_BASE + 8'(i)) lvl_r[i] <= reg_wdata_in;
      end
    end
  end
  function automatic logic [31:0] wide(input logic [3:0] s);
    for (int i = 0; i < 4; i++) wide[i*8+:8] = {8{s[i]}};
  endfunction
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_STATE_ONEHOT: assert property ($onehot(pattern_state_out))
    else $error("state not one-hot");
  AST_AUDIO_PASS: assert property (
    ((led_drive_out ^ $past(audio_level_in)) & wide($past(sel_r))) == 32'h0)
    else $error("audio channel not passed through");
  AST_RDATA_SEL: assert property ($past(reg_addr_in) == ADDR_AUDIO_SEL
    |-> reg_rdata_out[3:0] == $past(sel_r)) else $error("select readback wrong");
  AST_UNMAPPED_ZERO: assert property (
    $past(reg_addr_in) > ADDR_CTRL && $past(reg_addr_in) != ADDR_AUDIO_SEL
    |-> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  AST_ENABLE_START: assert property (pattern_state_out == ST_IDLE && en_r
    |-> ##[1:2] pattern_state_out == ST_RISE) else $error("enable did not start rise");
  AST_DISABLE_IDLE: assert property (!en_r |=> ##1 pattern_state_out == ST_IDLE)
    else $error("disabled but not idle");
  AST_DARK_STAGES: assert property (
    (pattern_state_out inside {ST_IDLE, ST_GAP, ST_OFF})[*2]
    |=> (led_drive_out & ~wide($past(sel_r))) == 32'h0) else $error("dark stage lit");
  AST_ON_LEVEL: assert property ((pattern_state_out == ST_ON)[*2] |->
    ((led_drive_out ^ $past(lvl_r)) & ~wide($past(sel_r))) == 32'h0)
    else $error("on level wrong");
  AST_ON_TO_FALL: assert property (
    pattern_state_out == ST_ON ##1 pattern_state_out != ST_ON
    |-> pattern_state_out inside {ST_FALL, ST_IDLE}) else $error("on not followed by fall");
  AST_GAP_TO_RISE: assert property (
    pattern_state_out == ST_GAP ##1 pattern_state_out != ST_GAP
    |-> pattern_state_out inside {ST_RISE, ST_IDLE}) else $error("gap not followed by rise");
  COV_GAP: cover property (pattern_state_out == ST_GAP);
  COV_OFF_RISE: cover property (pattern_state_out == ST_OFF ##1 pattern_state_out == ST_RISE);
  COV_SEL_READ: cover property ($past(reg_addr_in) == ADDR_AUDIO_SEL && reg_rdata_out != 8'h00);
endmodule
bind lbpg_top lbpg_top_sva u_sva (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rdata_out(reg_rdata_out), .audio_level_in(audio_level_in),
  .led_drive_out(led_drive_out), .pattern_state_out(pattern_state_out));

// >>> lbpg_top_tb_top.sv
// Self-checking testbench for the LED breath pattern generator
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module lbpg_top_tb_top import lbpg_pkg::*;;
  localparam int TK = 10;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [NUM_CH-1:0][7:0] audio_level_in = 32'h5ac30fe1;
  logic [NUM_CH-1:0][7:0] led_drive_out;
  logic [5:0] pattern_state_out;
  logic [NUM_CH-1:0][7:0] lv = 32'hb4835221;
  int bad_count = 0;
  int n_compared = 0;
  logic rec = 1'b0;
  logic [5:0] st_q[$];
  int len_q[$];
  always #20 sys_clk_in = ~sys_clk_in;
  lbpg_top #(.TICK_CYC(TK)) u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rdata_out(reg_rdata_out), .audio_level_in(audio_level_in),
    .led_drive_out(led_drive_out), .pattern_state_out(pattern_state_out));
  // Stage order and stage lengths in cycles
  always @(posedge sys_clk_in) begin
    if (rec && st_q.size() > 0 && pattern_state_out === st_q[$]) begin
      len_q[len_q.size()-1]++;
    end else if (rec) begin
      st_q.push_back(pattern_state_out);
      len_q.push_back(1);
    end
  end
  task automatic give_verdict;
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    repeat (2) @(posedge sys_clk_in);
    #1 d = reg_rdata_out;
  endtask
  task automatic wait_st(input logic [5:0] s);
    int n;
    n = 0;
    while (pattern_state_out !== s && n < 9000) begin
      @(posedge sys_clk_in);
      #1 n++;
    end
    if (n >= 9000) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic chk_run(input logic [5:0] e[$]);
    `CHK("stage count", e.size(), st_q.size())
    foreach (e[i]) `CHK("stage", e[i], st_q[i])
  endtask
  initial begin
    logic [7:0] d;
    logic [31:0] ex;
    repeat (5) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(ADDR_AUDIO_SEL, d);
    `CHK("sel reset", 8'h00, d)
    `CHK("idle state", 6'h01, pattern_state_out)
    for (int i = 0; i < NUM_CH; i++) wr(ADDR_CH_LEVEL_BASE + 8'(i), lv[i]);
    wr(ADDR_AUDIO_SEL, 8'h05);
    rd(ADDR_AUDIO_SEL, d);
    `CHK("sel rw", 8'h05, d)
    ex = {8'h00, audio_level_in[2], 8'h00, audio_level_in[0]};
    `CHK("audio drive", ex, led_drive_out)
    wr(8'h30, 8'h5a);
    rd(8'h30, d);
    `CHK("unmapped", 8'h00, d)
    wr(ADDR_AUDIO_SEL, 8'h00);
    rec <= 1'b1;
    wr(ADDR_CTRL, 8'h01);
    wait_st(ST_ON);
    repeat (3) @(posedge sys_clk_in);
    #1 `CHK("on levels", lv, led_drive_out)
    wait_st(ST_OFF);
    wait_st(ST_RISE);
    rec <= 1'b0;
    chk_run('{ST_IDLE, ST_RISE, ST_ON, ST_FALL, ST_OFF});
    `CHK("on len", 1'b1, len_q[2] inside {[50*TK:50*TK+2]})
    `CHK("off len", 1'b1, len_q[4] inside {[80*TK:80*TK+2]})
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_GAP, 8'hff);
    wr(ADDR_AUDIO_SEL, 8'h08);
    st_q.delete();
    len_q.delete();
    rec <= 1'b1;
    wr(ADDR_CTRL, 8'h17);
    wait_st(ST_OFF);
    wait_st(ST_RISE);
    rec <= 1'b0;
    chk_run('{ST_IDLE, ST_RISE, ST_ON, ST_FALL, ST_GAP,
      ST_RISE, ST_ON, ST_FALL, ST_OFF});
    `CHK("gap len", 1'b1, len_q[4] inside {[540*TK:540*TK+2]})
    `CHK("second on len", len_q[2], len_q[6])
    `CHK("ch4 audio", audio_level_in[3], led_drive_out[3])
    wr(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge sys_clk_in);
    #1 `CHK("off drive", {audio_level_in[3], 24'h0}, led_drive_out)
    // Slow rise: sample mid phase step 8, linear then log shape
    wr(ADDR_AUDIO_SEL, 8'h00);
    wr(ADDR_RISE, 8'h01);
    wr(ADDR_CTRL, 8'h05);
    wait_st(ST_RISE);
    repeat (8 * RAMP_CYC + RAMP_CYC / 2) @(posedge sys_clk_in);
    #1 `CHK("linear ramp", 32'h05040201, led_drive_out)
    `CHK("still rising", ST_RISE, pattern_state_out)
    wr(ADDR_CTRL, 8'h01);
    repeat (3) @(posedge sys_clk_in);
    #1 `CHK("log ramp", 32'h00000000, led_drive_out)
    give_verdict();
  end
endmodule
